// File: design/pcd_pkg.sv
package pcd_pkg;
	localparam int          CMD_W         = 24;
	localparam int          DATA_W        = 16;
	localparam int          OP_HI         = 23;
	localparam int          OP_LO         = 18;
	localparam int          XFER_HI       = 17;
	localparam int          XFER_LO       = 15;
	localparam int          REGNUM_HI     = 13;
	localparam int          REGNUM_LO     = 8;
	localparam int          UNIT_HI       = 7;
	localparam int          UNIT_LO       = 0;
	localparam logic [5:0]  OPCODE_SEL    = 6'h06;
	localparam logic [7:0]  UNIT_TESTER   = 8'h50;
	localparam logic [5:0]  REG_MODE      = 6'h01;
	localparam logic [5:0]  REG_INSTR_NUM = 6'h0C;
	localparam logic [5:0]  REG_SUPPLY1   = 6'h11;
	localparam logic [15:0] MODE_RESET    = 16'h0000;
	localparam logic [15:0] INSTR_RESET   = 16'h0000;
	localparam logic [15:0] SUPPLY_RESET  = 16'h0000;
	localparam logic [7:0]  AXI_CMD       = 8'h00;
	localparam logic [7:0]  AXI_WDATA     = 8'h04;
	localparam logic [7:0]  AXI_STATUS    = 8'h08;
	localparam logic [7:0]  AXI_RDATA     = 8'h0C;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [2:0] {
		PCD_XFER_NOP     = 3'h0,
		PCD_XFER_SPECIAL = 3'h2,
		PCD_XFER_WRITE   = 3'h4,
		PCD_XFER_READ    = 3'h6
	} pcd_xfer_t;
	function automatic logic [23:0] pcd_cmd(input logic [2:0] x,
		input logic [5:0] r, input logic [7:0] u);
		pcd_cmd = {OPCODE_SEL, x, 1'b0, r, u};
	endfunction
endpackage

// File: design/pcd_link_if.sv
interface pcd_link_if;
	import pcd_pkg::*;
	logic [CMD_W-1:0]  cmd;
	logic              cmd_valid;
	logic [DATA_W-1:0] wdata;
	logic              wdata_valid;
	logic [DATA_W-1:0] rdata;
	logic              rdata_valid;
	modport device (input cmd, cmd_valid, wdata, wdata_valid,
		output rdata, rdata_valid);
	modport host (output cmd, cmd_valid, wdata, wdata_valid,
		input rdata, rdata_valid);
endinterface

// File: design/pcd_cmd_fields.sv
module pcd_cmd_fields
	import pcd_pkg::*;
(
	input  wire logic [CMD_W-1:0] cmd,      // Command word
	output pcd_xfer_t             xfer,     // Transfer type
	output logic [5:0]            regnum,   // Register number
	output logic                  for_us    // Op code and unit match
);
	assign xfer   = pcd_xfer_t'(cmd[XFER_HI:XFER_LO]);
	assign regnum = cmd[REGNUM_HI:REGNUM_LO];
	assign for_us = (cmd[OP_HI:OP_LO] == OPCODE_SEL)
		&& (cmd[UNIT_HI:UNIT_LO] == UNIT_TESTER);
endmodule

// File: design/pcd_device.sv
// Contract
// - Command is one 24-bit word, eight octal digits
// - Bits 23..18 hold op code octal 06
// - Bits 17..15: 6 read, 4 write, 2 special
// - Bits 13..8 select one of 64 registers
// - Respond only to unit octal 120
// - Read returns register contents to host
// - Write command then data word, data latched
// - Special performs register action, no data
// - Station registers use long bus, not here
// - Mode register is short register 1
// - Special on mode register clears it
module pcd_device
	import pcd_pkg::*;
(
	input  wire logic        aclk,          // Clock
	input  wire logic        aresetn,       // Sync reset, low
	pcd_link_if.device       link,          // Command link
	output logic [15:0]      mode_out,      // Mode register contents
	output logic [15:0]      instr_num,     // Instruction number
	output logic             supply_on      // Supply connected
);
	pcd_xfer_t   xfer;
	logic [5:0]  regnum;
	logic        for_us;
	logic        wr_pend_r;
	logic [5:0]  wr_reg_r;
	logic [15:0] mode_r;
	logic [15:0] instr_r;
	logic [15:0] supply_r;
	logic        supply_on_r;
	logic [15:0] rdata_r;
	logic        rvalid_r;
	logic        take;

	pcd_cmd_fields u_fields (
		.cmd    (link.cmd),
		.xfer   (xfer),
		.regnum (regnum),
		.for_us (for_us)
	);

	assign take = link.cmd_valid && for_us;

	function automatic logic [15:0] rd_mux(input logic [5:0] r,
		input logic [15:0] m, input logic [15:0] i, input logic [15:0] s);
		unique case (r)
			REG_MODE:      rd_mux = m;
			REG_INSTR_NUM: rd_mux = i;
			REG_SUPPLY1:   rd_mux = s;
			default:       rd_mux = 16'h0000;
		endcase
	endfunction

	// Pending write: data word follows the write command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_pend_r <= 1'b0;
			wr_reg_r  <= 6'h00;
		end else if (take && xfer == PCD_XFER_WRITE) begin
			wr_pend_r <= 1'b1;
			wr_reg_r  <= regnum;
		end else if (take || link.wdata_valid) begin
			wr_pend_r <= 1'b0;
		end
	end

	wire wr_now = wr_pend_r && link.wdata_valid;
	wire spec   = take && xfer == PCD_XFER_SPECIAL;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= MODE_RESET;
		end else if (spec && regnum == REG_MODE) begin
			mode_r <= MODE_RESET;
		end else if (wr_now && wr_reg_r == REG_MODE) begin
			mode_r <= link.wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_r <= INSTR_RESET;
		end else if (spec && regnum == REG_INSTR_NUM) begin
			instr_r <= instr_r + 16'h0001;
		end else if (wr_now && wr_reg_r == REG_INSTR_NUM) begin
			instr_r <= link.wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_r    <= SUPPLY_RESET;
			supply_on_r <= 1'b0;
		end else if (spec && regnum == REG_SUPPLY1) begin
			supply_on_r <= 1'b0;
		end else if (wr_now && wr_reg_r == REG_SUPPLY1) begin
			supply_r    <= link.wdata;
			supply_on_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= take && xfer == PCD_XFER_READ;
			if (take && xfer == PCD_XFER_READ) begin
				rdata_r <= rd_mux(regnum, mode_r, instr_r, supply_r);
			end
		end
	end

	assign link.rdata       = rdata_r;
	assign link.rdata_valid = rvalid_r;
	assign mode_out         = mode_r;
	assign instr_num        = instr_r;
	assign supply_on        = supply_on_r;
endmodule

// File: design/pcd_host.sv
module pcd_host
	import pcd_pkg::*;
(
	input  wire logic        aclk,          // Clock
	input  wire logic        aresetn,       // Sync reset, low
	pcd_link_if.host         link,          // Command link
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Write response valid
	input  wire logic        s_axi_bready,  // Write response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read data valid
	input  wire logic        s_axi_rready   // Read data ready
);
	typedef enum logic [1:0] {
		PCD_H_IDLE = 2'h0,
		PCD_H_CMD  = 2'h1,
		PCD_H_DATA = 2'h2,
		PCD_H_WAIT = 2'h3
	} pcd_hstate_t;

	pcd_hstate_t st_r;
	logic [23:0] cmd_r;
	logic [15:0] wd_r;
	logic [15:0] rd_r;
	logic        aw_r, w_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdat_r;
	logic        bvalid_r, rvalid_r;
	logic [1:0]  bresp_r, rresp_r;
	logic [31:0] rdat_r;

	assign s_axi_awready = !aw_r && !bvalid_r;
	assign s_axi_wready  = !w_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	wire wr_go = aw_r && w_r && !bvalid_r;
	wire busy  = st_r != PCD_H_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r     <= 1'b0;
			w_r      <= 1'b0;
			awaddr_r <= 8'h00;
			wdat_r   <= 32'h0;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r     <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_r    <= 1'b1;
				wdat_r <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_r     <= 1'b0;
				w_r      <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (awaddr_r == AXI_CMD || awaddr_r == AXI_WDATA)
					? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	wire cmd_wr = wr_go && awaddr_r == AXI_CMD && !busy;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_r <= 24'h0;
			wd_r  <= 16'h0;
		end else begin
			if (cmd_wr) cmd_r <= wdat_r[23:0];
			if (wr_go && awaddr_r == AXI_WDATA) wd_r <= wdat_r[15:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= PCD_H_IDLE;
			rd_r <= 16'h0;
		end else begin
			unique case (st_r)
				PCD_H_IDLE: if (cmd_wr) st_r <= PCD_H_CMD;
				PCD_H_CMD: begin
					if (cmd_r[XFER_HI:XFER_LO] == PCD_XFER_WRITE)
						st_r <= PCD_H_DATA;
					else if (cmd_r[XFER_HI:XFER_LO] == PCD_XFER_READ
						&& cmd_r[OP_HI:OP_LO] == OPCODE_SEL
						&& cmd_r[UNIT_HI:UNIT_LO] == UNIT_TESTER)
						st_r <= PCD_H_WAIT;
					else
						st_r <= PCD_H_IDLE;
				end
				PCD_H_DATA: st_r <= PCD_H_IDLE;
				PCD_H_WAIT: if (link.rdata_valid) begin
					rd_r <= link.rdata;
					st_r <= PCD_H_IDLE;
				end
			endcase
		end
	end

	assign link.cmd         = cmd_r;
	assign link.cmd_valid   = st_r == PCD_H_CMD;
	assign link.wdata       = wd_r;
	assign link.wdata_valid = st_r == PCD_H_DATA;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdat_r   <= 32'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= RESP_OKAY;
			unique case (s_axi_araddr)
				AXI_CMD:    rdat_r <= {8'h00, cmd_r};
				AXI_WDATA:  rdat_r <= {16'h0000, wd_r};
				AXI_STATUS: rdat_r <= {31'h0, busy};
				AXI_RDATA:  rdat_r <= {16'h0000, rd_r};
				default: begin
					rdat_r  <= 32'h0;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdat_r;
endmodule

// File: dv/pcd_link_monitor.sv
module pcd_link_monitor
	import pcd_pkg::*;
(
	input wire logic             aclk,        // Clock
	input wire logic             aresetn,     // Reset, low
	input wire logic [CMD_W-1:0] cmd,         // Command word
	input wire logic             cmd_valid,   // Command pulse
	input wire logic             wdata_valid, // Data pulse
	input wire logic             rdata_valid  // Answer pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic ours = cmd_valid && cmd[OP_HI:OP_LO] == OPCODE_SEL
		&& cmd[UNIT_HI:UNIT_LO] == UNIT_TESTER;
	wire logic [2:0] xf = cmd[XFER_HI:XFER_LO];
	a_read_answered: assert property (ours && xf == 3'h6 |=> rdata_valid)
		else $error("read not answered");
	a_foreign_quiet: assert property (cmd_valid && !ours |=> !rdata_valid)
		else $error("foreign command answered");
	a_write_data: assert property (ours && xf == 3'h4 |=> wdata_valid)
		else $error("write data missing");
	a_data_cause: assert property (wdata_valid |-> $past(xf) == 3'h4
		&& $past(cmd_valid)) else $error("stray write data");
	a_answer_cause: assert property (rdata_valid |-> $past(ours)
		&& $past(xf) == 3'h6) else $error("stray answer");
	a_special_quiet: assert property (ours && xf == 3'h2
		|=> !rdata_valid && !wdata_valid) else $error("special moved data");
	a_nop_quiet: assert property (ours && xf == 3'h0
		|=> !rdata_valid && !wdata_valid) else $error("no-op moved data");
	a_answer_pulse: assert property (rdata_valid |=> !rdata_valid)
		else $error("answer too long");
	a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
		else $error("command too long");
	c_read: cover property (ours && xf == 3'h6 ##1 rdata_valid);
	c_write: cover property (ours && xf == 3'h4 ##1 wdata_valid);
	c_special: cover property (ours && xf == 3'h2);
endmodule

// File: dv/tb_top.sv
module tb_top
	import pcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, supply_on;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] mode_out, instr_num;
	int fails = 0, checks_done = 0, seed = 2936;
	int mode_m = 0, instr_m = 0, sup_m = 0, sup_d = 0, last_m = 0;
	logic [2:0] xs[4] = '{3'h0, 3'h2, 3'h4, 3'h6};
	logic [5:0] rg[4] = '{REG_MODE, REG_INSTR_NUM, REG_SUPPLY1, 6'h05};
	pcd_link_if link();
	always #20 aclk = ~aclk;
	pcd_device pcd_device_i(.aclk, .aresetn, .link(link), .mode_out,
		.instr_num, .supply_on);
	pcd_host pcd_host_i(.aclk, .aresetn, .link(link), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	pcd_link_monitor pcd_link_monitor_i(.aclk, .aresetn, .cmd(link.cmd),
		.cmd_valid(link.cmd_valid), .wdata_valid(link.wdata_valid),
		.rdata_valid(link.rdata_valid));
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		r = RESP_SLVERR;
		for (n = 0; n < 64; n++) begin
			// Settled values here are what the next rising edge samples
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid && s_axi_bready;
			if (b_t)
				r = s_axi_bresp;
			@(posedge aclk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
			if (b_t) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 64) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ar_t, r_t;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		d = 32'h0;
		r = RESP_SLVERR;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid && s_axi_rready;
			if (r_t) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
			@(posedge aclk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
			if (r_t) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 64) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic do_cmd(input logic [5:0] op, input logic [2:0] x,
		input logic [5:0] r, input logic [7:0] u, input logic [15:0] d);
		logic [1:0] rs;
		logic [31:0] v;
		int n;
		axi_wr(AXI_WDATA, {16'h0000, d}, rs);
		axi_wr(AXI_CMD, {8'h00, op, x, 1'b0, r, u}, rs);
		chk(rs, RESP_OKAY);
		for (n = 0; n < 32; n++) begin
			axi_rd(AXI_STATUS, v, rs);
			if (v[0] === 1'b0)
				break;
		end
		if (n == 32) begin
			fails++;
			report_and_stop();
		end
		if (op == OPCODE_SEL && u == UNIT_TESTER) begin
			if (x == 3'h4 && r == REG_MODE)
				mode_m = d;
			if (x == 3'h4 && r == REG_INSTR_NUM)
				instr_m = d;
			if (x == 3'h4 && r == REG_SUPPLY1) begin
				sup_d = d;
				sup_m = 1;
			end
			if (x == 3'h2 && r == REG_MODE)
				mode_m = 0;
			if (x == 3'h2 && r == REG_INSTR_NUM)
				instr_m = (instr_m + 1) & 16'hFFFF;
			if (x == 3'h2 && r == REG_SUPPLY1)
				sup_m = 0;
			if (x == 3'h6)
				last_m = r == REG_MODE ? mode_m : r == REG_INSTR_NUM
					? instr_m : r == REG_SUPPLY1 ? sup_d : 0;
		end
		axi_rd(AXI_RDATA, v, rs);
		chk(rs, RESP_OKAY);
		chk(v[15:0], last_m);
		chk(mode_out, mode_m);
		chk(instr_num, instr_m);
		chk(supply_on, sup_m);
	endtask
	initial begin
		int i;
		logic [1:0] r2;
		logic [31:0] v;
		logic [5:0] op;
		logic [7:0] u;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 48; i++) begin
			op = ($random(seed) % 6 == 0) ? 6'h07 : OPCODE_SEL;
			u = ($random(seed) % 6 == 0) ? 8'h51 : UNIT_TESTER;
			v = $random(seed);
			do_cmd(op, xs[i % 4], rg[(i / 4) % 4], u, v[15:0]);
		end
		axi_wr(8'h10, 32'h0, r2);
		chk(r2, RESP_SLVERR);
		axi_rd(8'h14, v, r2);
		chk(r2, RESP_SLVERR);
		report_and_stop();
	end
endmodule
